// file: verilog/dpucr_regs.svh
// Register offsets, field positions and reset values of the PHY user register bank
`ifndef DPUCR_REGS_SVH
`define DPUCR_REGS_SVH

// Byte offsets within the controller's 4KB configuration page
`define DPUCR_PAGE_MASK         12'hFFF
`define DPUCR_OFF_STATE         12'h300
`define DPUCR_OFF_CFG0          12'h304
`define DPUCR_OFF_CFG1          12'h308
`define DPUCR_OFF_CFG2          12'h310

// Field of the first configuration word
`define DPUCR_FRS_MSB           26
`define DPUCR_FRS_LSB           24

// Reset values
`define DPUCR_CFG0_RST          32'h7C924924
`define DPUCR_CFG1_RST          32'h008A28A2
`define DPUCR_CFG2_RST          32'h00000000
`define DPUCR_STATE_RST         16'h0000

// Read answer for write-only words
`define DPUCR_WO_READ           32'h00000000

// Frequency-range codes
`define DPUCR_FRS_250_266       3'h4
`define DPUCR_FRS_214_250       3'h5
`define DPUCR_FRS_200_214       3'h6
`define DPUCR_FRS_125_200       3'h7

`endif

// file: verilog/dpucr_pkg.sv
// Types shared by the PHY user register bank
`default_nettype none
package dpucr_pkg;

    typedef enum logic [2:0] {
        DPUCR_SEL_NONE,
        DPUCR_SEL_STATE,
        DPUCR_SEL_CFG0,
        DPUCR_SEL_CFG1,
        DPUCR_SEL_CFG2
    } dpucr_sel_e;

    typedef logic [31:0] dpucr_word_t;
    typedef logic [15:0] dpucr_half_t;
    typedef logic [11:0] dpucr_off_t;

endpackage
`default_nettype wire

// file: verilog/dpucr_cfg_word.sv
// One write-only configuration word holding its last written value
`timescale 1ns/1ps
`default_nettype none
module dpucr_cfg_word
    import dpucr_pkg::*;
#(
    parameter dpucr_word_t RST_VAL = 32'h00000000
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        wr_en,
    input  wire dpucr_word_t wr_data,
    output logic             wr_seen,
    output dpucr_word_t      value
);

    typedef struct packed {
        dpucr_word_t word;
        logic        seen;
    } dpucr_cw_s;

    dpucr_cw_s st_ff;
    dpucr_cw_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (wr_en) begin
            nxt_st.word = wr_data;
            nxt_st.seen = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{word: RST_VAL, seen: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign value   = st_ff.word;
    assign wr_seen = st_ff.seen;

endmodule // dpucr_cfg_word
`default_nettype wire

// file: verilog/dpucr_decode.sv
// Address decode of the register page
`timescale 1ns/1ps
`default_nettype none
`include "dpucr_regs.svh"
module dpucr_decode
    import dpucr_pkg::*;
(
    input  wire logic [31:0] paddr,
    output dpucr_sel_e       sel
);

    function automatic dpucr_sel_e dec(input dpucr_off_t off);
        dpucr_sel_e s;
        s = DPUCR_SEL_NONE;
        unique case (off)
            `DPUCR_OFF_STATE: s = DPUCR_SEL_STATE;
            `DPUCR_OFF_CFG0:  s = DPUCR_SEL_CFG0;
            `DPUCR_OFF_CFG1:  s = DPUCR_SEL_CFG1;
            `DPUCR_OFF_CFG2:  s = DPUCR_SEL_CFG2;
            default:          s = DPUCR_SEL_NONE;
        endcase
        return s;
    endfunction

    // Only the offset within the 4KB page matters
    always_comb begin
        sel = dec(paddr[11:0] & `DPUCR_PAGE_MASK);
    end

endmodule // dpucr_decode
`default_nettype wire

// file: verilog/dpucr_top.sv
// APB register bank driving the DDR2 PHY user control signals
//
// Functional notes
// - First word bits 26:24 drive the delay-line frequency-range select bus.
// - Configuration words are write-only; their read-back is not defined.
// - Second word is all reserved and reads as zero.
// - A 16-bit status word samples the PHY interface state but always reads as zero.
// - Status bits 15:0 are reserved, read zero, not to be modified.
// - All words sit inside the controller's 4KB configuration page.
`timescale 1ns/1ps
`default_nettype none
`include "dpucr_regs.svh"
module dpucr_top
    import dpucr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic [2:0]       delay_line_freq_range,
    output logic [31:0]      phy_cfg_word0,
    output logic [31:0]      phy_cfg_word1,
    output logic [31:0]      phy_cfg_word2,
    output logic             phy_cfg_loaded,
    input  wire logic [15:0] phy_state_in
);

    // ------------------------------------------------------------
    // Bank state
    // ------------------------------------------------------------
    typedef struct packed {
        dpucr_word_t rdata;
        logic        err;
        dpucr_half_t state_sync1;
        dpucr_half_t state_sync2;
    } dpucr_top_s;

    dpucr_top_s  st_ff;
    dpucr_top_s  nxt_st;
    dpucr_sel_e  sel;
    logic        setup;
    logic        access;
    logic        wr0;
    logic        wr1;
    logic        wr2;
    logic [2:0]  seen;
    dpucr_word_t cfg0;
    dpucr_word_t cfg1;
    dpucr_word_t cfg2;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    dpucr_decode u_decode (
        .paddr (paddr),
        .sel   (sel)
    );

    assign setup  = psel && !penable;
    assign access = psel && penable;

    // Writes land at the access edge; zero wait states
    assign wr0 = access && pwrite && (sel == DPUCR_SEL_CFG0);
    assign wr1 = access && pwrite && (sel == DPUCR_SEL_CFG1);
    assign wr2 = access && pwrite && (sel == DPUCR_SEL_CFG2);

    // ------------------------------------------------------------
    // Configuration words
    // ------------------------------------------------------------
    dpucr_cfg_word #(.RST_VAL(`DPUCR_CFG0_RST)) u_cfg0 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr0),
        .wr_data (pwdata),
        .wr_seen (seen[0]),
        .value   (cfg0)
    );

    dpucr_cfg_word #(.RST_VAL(`DPUCR_CFG1_RST)) u_cfg1 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr1),
        .wr_data (pwdata),
        .wr_seen (seen[1]),
        .value   (cfg1)
    );

    dpucr_cfg_word #(.RST_VAL(`DPUCR_CFG2_RST)) u_cfg2 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr2),
        .wr_data (pwdata),
        .wr_seen (seen[2]),
        .value   (cfg2)
    );

    // ------------------------------------------------------------
    // Read path and status sampling
    // ------------------------------------------------------------
    // Status comes from the PHY domain, so it is synchronised first.
    // Reading the setup-phase address lets prdata come from a flop.
    always_comb begin
        nxt_st             = st_ff;
        nxt_st.state_sync1 = phy_state_in;
        nxt_st.state_sync2 = st_ff.state_sync1;
        if (setup) begin
            nxt_st.err   = (sel == DPUCR_SEL_NONE);
            nxt_st.rdata = '0;
            if (!pwrite) begin
                unique case (sel)
                    // Reserved status bits read as zero whatever the PHY drives
                    DPUCR_SEL_STATE: nxt_st.rdata = {16'h0000, st_ff.state_sync2 & `DPUCR_STATE_RST};
                    // Write-only words return a fixed zero; no software may rely on it
                    DPUCR_SEL_CFG0:  nxt_st.rdata = `DPUCR_WO_READ;
                    DPUCR_SEL_CFG1:  nxt_st.rdata = `DPUCR_WO_READ;
                    DPUCR_SEL_CFG2:  nxt_st.rdata = `DPUCR_WO_READ;
                    DPUCR_SEL_NONE:  nxt_st.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready                = 1'b1;
    assign prdata                = st_ff.rdata;
    assign pslverr               = access && st_ff.err;
    assign delay_line_freq_range = cfg0[`DPUCR_FRS_MSB:`DPUCR_FRS_LSB];
    assign phy_cfg_word0         = cfg0;
    assign phy_cfg_word1         = cfg1;
    assign phy_cfg_word2         = cfg2;
    assign phy_cfg_loaded        = seen[0];

    logic unused_ok;
    assign unused_ok = ^{pstrb, paddr[31:12], seen[2:1]};

endmodule // dpucr_top
`default_nettype wire

// file: sim/dpucr_top_sva.sv
// Assertions on the ports of the PHY user register bank
`timescale 1ns/1ps
`default_nettype none
module dpucr_top_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [2:0]  delay_line_freq_range,
    input wire logic [31:0] phy_cfg_word0,
    input wire logic [31:0] phy_cfg_word1,
    input wire logic [31:0] phy_cfg_word2,
    input wire logic        phy_cfg_loaded
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence wr0_s;
        psel && penable && pwrite && paddr[11:0] == 12'h304;
    endsequence
    sequence rd_s(o);
        psel && penable && !pwrite && paddr[11:0] == o;
    endsequence
    freq_map_a: assert property (delay_line_freq_range == phy_cfg_word0[26:24])
        else $error("freq range map");
    word0_load_a: assert property (wr0_s |=> phy_cfg_word0 == $past(pwdata))
        else $error("word0 load");
    words_hold_a: assert property (!(psel && penable && pwrite) |=>
        $stable({phy_cfg_word0, phy_cfg_word1, phy_cfg_word2})) else $error("words hold");
    state_zero_a: assert property (rd_s(12'h300) |-> prdata == 32'h0)
        else $error("state read");
    word1_zero_a: assert property (rd_s(12'h308) |-> prdata == 32'h0)
        else $error("word1 read");
    zero_wait_a: assert property (psel && penable |-> pready)
        else $error("wait state");
    mapped_ok_a: assert property (psel && penable && paddr[11:0] inside
        {12'h300, 12'h304, 12'h308, 12'h310} |-> !pslverr) else $error("mapped error");
    loaded_set_a: assert property (wr0_s |=> phy_cfg_loaded [*2])
        else $error("loaded flag");
endmodule // dpucr_top_sva
bind dpucr_top dpucr_top_sva chk (.*);
`default_nettype wire

// file: sim/dpucr_phy_model.sv
// Behavioural model of the PHY logic beyond the register bank
`timescale 1ns/1ps
`default_nettype none
module dpucr_phy_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [2:0]  delay_line_freq_range,
    output logic      [15:0] phy_state_in,
    output logic             bad_band
);
    // Status flips every cycle, so a zero read cannot come from a quiet line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phy_state_in <= 16'hA5C3;
        end else begin
            phy_state_in <= phy_state_in ^ 16'h5A5A;
        end
    end
    assign bad_band = ~delay_line_freq_range[2];
endmodule // dpucr_phy_model
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench of the PHY user register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dpucr_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, loaded, bad, er;
    dpucr_word_t paddr, pwdata, prdata, w0, w1, w2, rd, seed, e2;
    logic [2:0]  frs;
    logic [15:0] state;
    int          fails, checks;
    always #2 pclk = ~pclk;
    dpucr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .delay_line_freq_range(frs), .phy_cfg_word0(w0), .phy_cfg_word1(w1), .phy_cfg_word2(w2),
        .phy_cfg_loaded(loaded), .phy_state_in(state));
    dpucr_phy_model phy (.pclk(pclk), .presetn(presetn), .delay_line_freq_range(frs),
        .phy_state_in(state), .bad_band(bad));
    function automatic dpucr_word_t xs(input dpucr_word_t s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic dpucr_word_t cfg0(input logic [2:0] c);
        return (32'h7C924924 & ~32'h07000000) | {5'h00, c, 24'h000000};
    endfunction
    task automatic chk(input string n, input dpucr_word_t e, input dpucr_word_t v);
        checks++;
        if (v !== e) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", n, e, v);
        end
    endtask
    // Setup cycle, then access held until pready is seen
    task automatic apb(input logic w, input dpucr_word_t a, input dpucr_word_t d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic words(input dpucr_word_t e0, input dpucr_word_t e2x, input logic l);
        @(negedge pclk);
        chk("word0", e0, w0);
        chk("freq_range", {29'h0, e0[26:24]}, {29'h0, frs});
        chk("word1", 32'h008A28A2, w1);
        chk("word2", e2x, w2);
        chk("loaded", {31'h0, l}, {31'h0, loaded});
        chk("band", 32'h0, {31'h0, bad});
    endtask
    task automatic report_and_stop;
        if (fails == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge pclk);
        fails++;
        report_and_stop();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite} = 5'h00;
        {paddr, pwdata} = 64'h0;
        seed = 32'h232F;
        e2 = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        words(32'h7C924924, 32'h0, 1'b0);
        for (int c = 4; c < 8; c++) begin
            apb(1'b1, 32'h304, cfg0(c[2:0]));
            words(cfg0(c[2:0]), e2, 1'b1);
        end
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            e2 = seed;
            apb(1'b1, {seed[31:12], 12'h310}, seed);
            apb(1'b0, {seed[31:12], 12'h300}, 32'h0);
            chk("state_read", 32'h0, rd);
            apb(1'b1, 32'h308, 32'h008A28A2);
            apb(1'b0, 32'h308, 32'h0);
            chk("word1_read", 32'h0, rd);
            chk("mapped_err", 32'h0, {31'h0, er});
            apb(1'b1, {seed[31:12], 12'h30C}, ~seed);
            chk("slverr", 32'h1, {31'h0, er});
            words(cfg0(3'h7), e2, 1'b1);
        end
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        words(32'h7C924924, 32'h0, 1'b0);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
